// >>> hw/anp_pkg.sv
// Register map, field positions and reset values of the next-page register bank
package anp_pkg;

  // Register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int IRQ_W  = 4;

  // Register offsets on the management port
  localparam logic [ADDR_W-1:0] REG_EXPANSION  = 5'h06;
  localparam logic [ADDR_W-1:0] REG_NP_TX      = 5'h07;
  localparam logic [ADDR_W-1:0] REG_NP_RX      = 5'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 5'h11;

  // Expansion status bit positions
  localparam int EXP_LP_AN_ABLE    = 0;
  localparam int EXP_PAGE_RX       = 1;
  localparam int EXP_LOCAL_NP_ABLE = 2;
  localparam int EXP_LP_NP_ABLE    = 3;
  localparam int EXP_PD_FAULT      = 4;

  // Code word bit positions, shared by transmit and receive words
  localparam int CW_NEXT_PAGE = 15;
  localparam int CW_ACK       = 14;
  localparam int CW_MSG_PAGE  = 13;
  localparam int CW_ACK2      = 12;
  localparam int CW_TOGGLE    = 11;

  // Reset and write values
  localparam logic                 LOCAL_NP_ABLE  = 1'h1;
  localparam logic [DATA_W-1:0]    NP_TX_RESET    = 16'h2001;
  localparam logic [DATA_W-1:0]    NP_TX_CLEARED  = 16'h0000;
  localparam logic [DATA_W-1:0]    NP_TX_WR_MASK  = 16'hb7ff;
  localparam logic [DATA_W-1:0]    NP_RX_RESET    = 16'h0000;
  localparam logic [DATA_W-1:0]    READ_IDLE      = 16'h0000;
  localparam logic [IRQ_W-1:0]     IRQ_MASK_RESET = 4'h0;
  localparam logic [IRQ_W-1:0]     IRQ_NONE       = 4'h0;

  // Interrupt status bit positions
  localparam int IRQ_PD_FAULT  = 0;
  localparam int IRQ_PAGE_RX   = 1;
  localparam int IRQ_LINK_FAIL = 2;
  localparam int IRQ_NP_TAKEN  = 3;

  // Address match, used by both the read and the write decode
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] offset);
    return addr == offset;
  endfunction

endpackage

// >>> hw/page_xfer_if.sv
// Carrier between the register bank and its transmit and receive page holders
`timescale 1ns/1ps
`default_nettype none
interface page_xfer_if;
  logic                      rst;
  logic                      wr;
  logic [anp_pkg::DATA_W-1:0] wdata;
  logic                      taken;
  logic                      link_fail;
  logic [anp_pkg::DATA_W-1:0] tx_word;
  logic                      loaded;
  logic                      capture;
  logic [anp_pkg::DATA_W-1:0] rx_in;
  logic [anp_pkg::DATA_W-1:0] rx_word;

  modport ctrl (output rst, wr, wdata, taken, link_fail, capture, rx_in,
                input  tx_word, loaded, rx_word);
  modport tx_end (input rst, wr, wdata, taken, link_fail,
                  output tx_word, loaded);
  modport rx_end (input rst, capture, rx_in,
                  output rx_word);
endinterface
`default_nettype wire

// >>> hw/np_tx_page.sv
// Next-page transmit word with its loaded flag and device-kept toggle
`timescale 1ns/1ps
`default_nettype none
module np_tx_page (
  input  wire logic        clock,
  page_xfer_if.tx_end      bus
);

  // Software fields, link-fail clear, toggle flip on each page sent in a cycle without a write
  always_ff @(posedge clock) begin
    if (bus.rst) begin
      bus.tx_word <= anp_pkg::NP_TX_RESET; // RULE9 RULE10 RULE11
    end else if (bus.link_fail) begin
      bus.tx_word <= anp_pkg::NP_TX_CLEARED; // RULE8
    end else if (bus.wr) begin
      // Toggle and reserved bit keep their value; only masked fields move
      bus.tx_word <= (bus.wdata & anp_pkg::NP_TX_WR_MASK)
                   | (bus.tx_word & ~anp_pkg::NP_TX_WR_MASK); // RULE9 RULE10 RULE11
    end else if (bus.taken) begin
      bus.tx_word[anp_pkg::CW_TOGGLE] <= ~bus.tx_word[anp_pkg::CW_TOGGLE]; // RULE11
    end
  end

  // Loaded flag: a write sets it and wins over the consume pulse
  always_ff @(posedge clock) begin
    if (bus.rst || bus.link_fail) begin
      bus.loaded <= 1'b0;
    end else if (bus.wr) begin
      bus.loaded <= 1'b1; // RULE7
    end else if (bus.taken) begin
      bus.loaded <= 1'b0;
    end
  end

  property p_toggle_ro;
    @(posedge clock) disable iff (bus.rst)
    bus.wr && !bus.link_fail |=> $stable(bus.tx_word[anp_pkg::CW_TOGGLE]);
  endproperty
  a_toggle_ro: assert property (p_toggle_ro) // RULE11
    else $error("toggle changed by a software write");

endmodule // np_tx_page
`default_nettype wire

// >>> hw/np_rx_page.sv
// Capture of the partner's received next-page code word
`timescale 1ns/1ps
`default_nettype none
module np_rx_page (
  input  wire logic        clock,
  page_xfer_if.rx_end      bus
);

  // Whole word taken on each page, acknowledge bit included
  always_ff @(posedge clock) begin
    if (bus.rst) begin
      bus.rx_word <= anp_pkg::NP_RX_RESET; // RULE12
    end else if (bus.capture) begin
      bus.rx_word <= bus.rx_in; // RULE12 RULE13
    end
  end

  property p_rx_capture;
    @(posedge clock) disable iff (bus.rst)
    bus.capture |=> bus.rx_word == $past(bus.rx_in);
  endproperty
  a_rx_capture: assert property (p_rx_capture) // RULE12
    else $error("received page not captured");

  property p_rx_ack;
    @(posedge clock) disable iff (bus.rst)
    bus.capture ##1 !bus.capture [*2] |->
      bus.rx_word[anp_pkg::CW_ACK] == $past(bus.rx_in[anp_pkg::CW_ACK], 2);
  endproperty
  a_rx_ack: assert property (p_rx_ack) // RULE13
    else $error("received acknowledge bit not held");

endmodule // np_rx_page
`default_nettype wire

// >>> hw/autoneg_next_page_regs.sv
// Auto-negotiation expansion status and next-page exchange register bank
//
// Behaviour
// RULE1: A parallel-detection fault sets expansion bit 4, which stays high until cleared.
// RULE2: Software ignores expansion bits until negotiation is reported complete.
// RULE3: Expansion bit 3 shows whether the partner advertised next-page ability.
// RULE4: Expansion bit 2 shows local next-page ability and reads 1 after any reset.
// RULE5: A newly received page sets expansion bit 1, which stays high until cleared.
// RULE6: Expansion bit 0 shows whether the partner takes part in negotiation.
// RULE7: Any write of the transmit page register marks a new page as loaded; a write in a link-failure cycle leaves the flag clear.
// RULE8: A link failure clears the transmit page register.
// RULE9: Transmit bits 15, 12 and 10:0 are writable, the message field resetting to 0x001.
// RULE10: The transmit message-page bit is writable and resets to 1.
// RULE11: The transmit toggle bit is kept by the device, read-only, resetting to 0.
// RULE12: The partner's received code word is captured read-only, resetting to zero.
// RULE13: Received bit 14 carries the partner's acknowledge beside toggle, ack2 and message page.
// RULE14: Reading the expansion register clears its latched-high bits.
// RULE15: Software loads the next page only after seeing a page received.
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs (
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic                         sw_reset,
  input  wire logic [anp_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [anp_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [anp_pkg::DATA_W-1:0]   reg_rdata,
  output logic                              irq,
  input  wire logic                         pd_fault,
  input  wire logic                         page_rx,
  input  wire logic [anp_pkg::DATA_W-1:0]   rx_code_word,
  input  wire logic                         lp_np_able,
  input  wire logic                         lp_an_able,
  input  wire logic                         link_fail,
  input  wire logic                         np_taken,
  output logic      [anp_pkg::DATA_W-1:0]   tx_code_word,
  output logic                              np_loaded
);

  // Both hardware and software reset restore the same values
  logic                          rst_any;
  logic                          pd_latched;
  logic                          page_latched;
  logic                          lp_np_seen;
  logic                          lp_an_seen;
  logic                          link_fail_prev;
  logic                          exp_read;
  logic                          tx_write;
  logic                          status_write;
  logic                          mask_write;
  logic [anp_pkg::IRQ_W-1:0]     irq_status;
  logic [anp_pkg::IRQ_W-1:0]     irq_mask;
  logic [anp_pkg::IRQ_W-1:0]     irq_events;
  logic [anp_pkg::IRQ_W-1:0]     next_irq_status;
  logic [anp_pkg::DATA_W-1:0]    exp_word;
  logic [anp_pkg::DATA_W-1:0]    next_rdata;

  page_xfer_if pg ();

  assign rst_any = srst | sw_reset;

  // Register decode from the plain management port
  assign exp_read     = reg_read  && anp_pkg::hit(reg_addr, anp_pkg::REG_EXPANSION);
  assign tx_write     = reg_write && anp_pkg::hit(reg_addr, anp_pkg::REG_NP_TX);
  assign status_write = reg_write && anp_pkg::hit(reg_addr, anp_pkg::REG_IRQ_STATUS);
  assign mask_write   = reg_write && anp_pkg::hit(reg_addr, anp_pkg::REG_IRQ_MASK);

  // Drive the page holders through the carrier
  assign pg.rst       = rst_any;
  assign pg.wr        = tx_write; // RULE7
  assign pg.wdata     = reg_wdata;
  assign pg.taken     = np_taken;
  assign pg.link_fail = link_fail; // RULE8
  assign pg.capture   = page_rx; // RULE12
  assign pg.rx_in     = rx_code_word;

  np_tx_page u_tx (
    .clock (clock),
    .bus   (pg)
  );

  np_rx_page u_rx (
    .clock (clock),
    .bus   (pg)
  );

  // Page holders already end in flip-flops, so these are plain wires
  assign tx_code_word = pg.tx_word;
  assign np_loaded    = pg.loaded;

  // Parallel-detection fault latch; a new fault beats the read clear
  always_ff @(posedge clock) begin
    if (rst_any) begin
      pd_latched <= 1'b0;
    end else if (pd_fault) begin
      pd_latched <= 1'b1; // RULE1
    end else if (exp_read) begin
      pd_latched <= 1'b0; // RULE14
    end
  end

  // Page-received latch; same set-over-clear priority
  always_ff @(posedge clock) begin
    if (rst_any) begin
      page_latched <= 1'b0;
    end else if (page_rx) begin
      page_latched <= 1'b1; // RULE5
    end else if (exp_read) begin
      page_latched <= 1'b0; // RULE14
    end
  end

  // Partner abilities are registered so reads see a settled value
  always_ff @(posedge clock) begin
    if (rst_any) begin
      lp_np_seen <= 1'b0;
      lp_an_seen <= 1'b0;
    end else begin
      lp_np_seen <= lp_np_able; // RULE3
      lp_an_seen <= lp_an_able; // RULE6
    end
  end

  // Expansion word; meaningful only once negotiation completes
  always_comb begin
    exp_word = anp_pkg::READ_IDLE;
    exp_word[anp_pkg::EXP_PD_FAULT]      = pd_latched; // RULE1
    exp_word[anp_pkg::EXP_LP_NP_ABLE]    = lp_np_seen; // RULE3
    exp_word[anp_pkg::EXP_LOCAL_NP_ABLE] = anp_pkg::LOCAL_NP_ABLE; // RULE4
    exp_word[anp_pkg::EXP_PAGE_RX]       = page_latched; // RULE5
    exp_word[anp_pkg::EXP_LP_AN_ABLE]    = lp_an_seen; // RULE6
  end

  // Link-fail edge detect, so a long outage raises one event
  always_ff @(posedge clock) begin
    if (rst_any) begin
      link_fail_prev <= 1'b0;
    end else begin
      link_fail_prev <= link_fail;
    end
  end

  // Interrupt events
  always_comb begin
    irq_events = anp_pkg::IRQ_NONE;
    irq_events[anp_pkg::IRQ_PD_FAULT]  = pd_fault;
    irq_events[anp_pkg::IRQ_PAGE_RX]   = page_rx;
    irq_events[anp_pkg::IRQ_LINK_FAIL] = link_fail && !link_fail_prev;
    irq_events[anp_pkg::IRQ_NP_TAKEN]  = np_taken;
  end

  // Write-one-to-clear status; an event in the clearing cycle survives
  always_comb begin
    next_irq_status = irq_status;
    if (status_write) begin
      next_irq_status = irq_status & ~reg_wdata[anp_pkg::IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge clock) begin
    if (rst_any) begin
      irq_status <= anp_pkg::IRQ_NONE;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Mask register; all sources masked after reset
  always_ff @(posedge clock) begin
    if (rst_any) begin
      irq_mask <= anp_pkg::IRQ_MASK_RESET;
    end else if (mask_write) begin
      irq_mask <= reg_wdata[anp_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt from the flop, one cycle behind the status
  always_ff @(posedge clock) begin
    if (rst_any) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read mux; unmapped offsets and idle cycles read as zero
  always_comb begin
    next_rdata = anp_pkg::READ_IDLE;
    if (reg_read) begin
      case (reg_addr)
        anp_pkg::REG_EXPANSION:  next_rdata = exp_word;
        anp_pkg::REG_NP_TX:      next_rdata = pg.tx_word; // RULE9
        anp_pkg::REG_NP_RX:      next_rdata = pg.rx_word; // RULE12 RULE13
        anp_pkg::REG_IRQ_STATUS: next_rdata[anp_pkg::IRQ_W-1:0] = irq_status;
        anp_pkg::REG_IRQ_MASK:   next_rdata[anp_pkg::IRQ_W-1:0] = irq_mask;
        default:                 next_rdata = anp_pkg::READ_IDLE;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst_any) begin
      reg_rdata <= anp_pkg::READ_IDLE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst_any);

  property p_pd_latch;
    pd_fault |=> pd_latched ##1 (pd_latched || $past(exp_read));
  endproperty
  a_pd_latch: assert property (p_pd_latch) // RULE1
    else $error("parallel fault not latched");

  property p_pd_hold;
    pd_latched && !exp_read |=> pd_latched;
  endproperty
  a_pd_hold: assert property (p_pd_hold) // RULE1
    else $error("parallel fault latch dropped without a read");

  property p_page_latch;
    page_rx ##1 !exp_read |=> reg_read && reg_addr == anp_pkg::REG_EXPANSION
      |=> reg_rdata[anp_pkg::EXP_PAGE_RX];
  endproperty
  a_page_latch: assert property (p_page_latch) // RULE5
    else $error("page received bit not reported");

  property p_read_clear;
    exp_read && !pd_fault && !page_rx |=> !pd_latched && !page_latched;
  endproperty
  a_read_clear: assert property (p_read_clear) // RULE14
    else $error("latched bits not cleared by read");

  property p_exp_view;
    exp_read |=> reg_rdata[anp_pkg::EXP_LOCAL_NP_ABLE]
      && reg_rdata[anp_pkg::EXP_LP_NP_ABLE] == $past(lp_np_able, 2)
      && reg_rdata[anp_pkg::EXP_LP_AN_ABLE] == $past(lp_an_able, 2);
  endproperty
  a_exp_view: assert property (p_exp_view) // RULE3 RULE4 RULE6
    else $error("expansion view wrong");

  property p_load_flag;
    tx_write && !link_fail |=> np_loaded;
  endproperty
  a_load_flag: assert property (p_load_flag) // RULE7
    else $error("write did not mark page loaded");

  property p_link_clear;
    link_fail |=> tx_code_word == anp_pkg::NP_TX_CLEARED && !np_loaded;
  endproperty
  a_link_clear: assert property (p_link_clear) // RULE8
    else $error("link failure did not clear transmit page");

  property p_tx_fields;
    tx_write && !link_fail |=>
      (tx_code_word & anp_pkg::NP_TX_WR_MASK) == ($past(reg_wdata) & anp_pkg::NP_TX_WR_MASK)
      && !tx_code_word[anp_pkg::CW_ACK];
  endproperty
  a_tx_fields: assert property (p_tx_fields) // RULE9 RULE10
    else $error("transmit fields not written");

  property p_tx_reset;
    @(posedge clock) disable iff (1'b0)
    rst_any |=> tx_code_word == anp_pkg::NP_TX_RESET;
  endproperty
  a_tx_reset: assert property (p_tx_reset) // RULE9 RULE10 RULE11
    else $error("transmit page reset value wrong");

  property p_rx_reset;
    @(posedge clock) disable iff (1'b0)
    rst_any |=> pg.rx_word == anp_pkg::NP_RX_RESET;
  endproperty
  a_rx_reset: assert property (p_rx_reset) // RULE12
    else $error("received page reset value wrong");

  property p_irq_level;
    |(irq_status & irq_mask) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not raised for unmasked status");

  property p_irq_set_wins;
    status_write && page_rx |=> irq_status[anp_pkg::IRQ_PAGE_RX];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins)
    else $error("event lost in clearing cycle");

endmodule // autoneg_next_page_regs
`default_nettype wire

// >>> bench/an_partner_model.sv
// Far-side model: link partner event sources and ability levels
`timescale 1ns/1ps
`default_nettype none
module an_partner_model (
  input  wire logic        clock,
  output logic             pd_fault,
  output logic             page_rx,
  output logic [15:0]      rx_code_word,
  output logic             lp_np_able,
  output logic             lp_an_able,
  output logic             link_fail,
  output logic             np_taken
);
  // Idle levels; the code word is not all zero so a stale capture shows
  initial begin
    pd_fault     = 1'h0;
    page_rx      = 1'h0;
    rx_code_word = 16'h5a5a;
    lp_np_able   = 1'h0;
    lp_an_able   = 1'h0;
    link_fail    = 1'h0;
    np_taken     = 1'h0;
  end

  // Page arrival; word is only valid with the pulse, then inverted
  task automatic page(input logic [15:0] w);
    page_rx      <= 1'h1;
    rx_code_word <= w;
    @(posedge clock);
    page_rx      <= 1'h0;
    rx_code_word <= ~w;
    @(posedge clock);
  endtask

  // One-cycle event pulses: 0 fault, 1 page taken, 2 link failure
  task automatic pulse(input int kind);
    pd_fault  <= (kind == 0);
    np_taken  <= (kind == 1);
    link_fail <= (kind == 2);
    @(posedge clock);
    pd_fault  <= 1'h0;
    np_taken  <= 1'h0;
    link_fail <= 1'h0;
    @(posedge clock);
  endtask

  // Partner ability levels, held between negotiations
  task automatic ability(input logic np, input logic an);
    lp_np_able <= np;
    lp_an_able <= an;
    @(posedge clock);
  endtask
endmodule // an_partner_model
`default_nettype wire

// >>> bench/autoneg_next_page_regs_tb.sv
// Self-checking bench for the next-page register bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module autoneg_next_page_regs_tb;
  logic        clock;
  logic        srst;
  logic        sw_reset;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic        irq;
  logic        pd_fault;
  logic        page_rx;
  logic [15:0] rx_code_word;
  logic        lp_np_able;
  logic        lp_an_able;
  logic        link_fail;
  logic        np_taken;
  logic [15:0] tx_code_word;
  logic        np_loaded;
  int          fails;
  int          n_checks;

  autoneg_next_page_regs autoneg_next_page_regs_i (
    .clock(clock), .srst(srst), .sw_reset(sw_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .pd_fault(pd_fault), .page_rx(page_rx),
    .rx_code_word(rx_code_word), .lp_np_able(lp_np_able), .lp_an_able(lp_an_able),
    .link_fail(link_fail), .np_taken(np_taken), .tx_code_word(tx_code_word),
    .np_loaded(np_loaded));

  an_partner_model an_partner_model_i (
    .clock(clock), .pd_fault(pd_fault), .page_rx(page_rx), .rx_code_word(rx_code_word),
    .lp_np_able(lp_np_able), .lp_an_able(lp_an_able), .link_fail(link_fail),
    .np_taken(np_taken));

  // 50 MHz clock
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // One-cycle write; an idle edge follows so strobes never merge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
    @(posedge clock);
  endtask

  // Read; data is looked at mid-cycle, clear of the edge that drops it
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    @(negedge clock);
    `CHECK(reg_rdata, exp)
    @(posedge clock);
  endtask

  // Settle a few cycles, then look at irq between edges
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clock);
    @(negedge clock);
    `CHECK(irq, exp)
    @(posedge clock);
  endtask

  task automatic t_reset_values;
    rd(5'h06, 16'h0004);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    rd(5'h11, 16'h0000);
    `CHECK(np_loaded, 1'h0)
    $display("test reset_values done");
  endtask

  task automatic t_abilities;
    an_partner_model_i.ability(1'h1, 1'h1);
    repeat (2) @(posedge clock);
    rd(5'h06, 16'h000d);
    an_partner_model_i.ability(1'h1, 1'h0);
    repeat (2) @(posedge clock);
    rd(5'h06, 16'h000c);
    an_partner_model_i.ability(1'h0, 1'h1);
    repeat (2) @(posedge clock);
    rd(5'h06, 16'h0005);
    $display("test abilities done");
  endtask

  task automatic t_latches;
    an_partner_model_i.page(16'h4a5c);
    rd(5'h08, 16'h4a5c);
    wr(5'h08, 16'hffff);
    rd(5'h08, 16'h4a5c);
    wr(5'h06, 16'hffff);
    rd(5'h06, 16'h0007);
    rd(5'h06, 16'h0005);
    an_partner_model_i.pulse(0);
    rd(5'h06, 16'h0015);
    rd(5'h06, 16'h0005);
    $display("test latches done");
  endtask

  task automatic t_transmit;
    // Answer the received page with exactly one loaded page
    an_partner_model_i.page(16'h8123);
    wr(5'h07, 16'hffff);
    @(negedge clock);
    `CHECK(np_loaded, 1'h1)
    `CHECK(tx_code_word, 16'hb7ff)
    @(posedge clock);
    rd(5'h07, 16'hb7ff);
    an_partner_model_i.pulse(1);
    @(negedge clock);
    `CHECK(np_loaded, 1'h0)
    @(posedge clock);
    rd(5'h07, 16'hbfff);
    wr(5'h07, 16'h0000);
    rd(5'h07, 16'h0800);
    wr(5'h07, 16'h9155);
    an_partner_model_i.pulse(2);
    @(negedge clock);
    `CHECK(tx_code_word, 16'h0000)
    `CHECK(np_loaded, 1'h0)
    @(posedge clock);
    rd(5'h07, 16'h0000);
    $display("test transmit done");
  endtask

  task automatic t_interrupts;
    wr(5'h10, 16'h000f);
    rd(5'h10, 16'h0000);
    wr(5'h11, 16'h0002);
    an_partner_model_i.page(16'h0001);
    irq_is(1'h1);
    rd(5'h10, 16'h0002);
    wr(5'h10, 16'h0002);
    irq_is(1'h0);
    an_partner_model_i.pulse(0);
    irq_is(1'h0);
    rd(5'h10, 16'h0001);
    wr(5'h11, 16'h0003);
    irq_is(1'h1);
    rd(5'h11, 16'h0003);
    wr(5'h10, 16'h0001);
    irq_is(1'h0);
    rd(5'h1f, 16'h0000);
    rd(5'h06, 16'h0017);
    // Link-fail edge and page-taken sources of the status register
    an_partner_model_i.pulse(1);
    an_partner_model_i.pulse(2);
    rd(5'h10, 16'h000c);
    $display("test interrupts done");
  endtask

  task automatic t_soft_reset;
    wr(5'h07, 16'h1234);
    an_partner_model_i.page(16'hffff);
    sw_reset <= 1'h1;
    @(posedge clock);
    sw_reset <= 1'h0;
    @(posedge clock);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    rd(5'h06, 16'h0005);
    `CHECK(np_loaded, 1'h0)
    $display("test soft_reset done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence; hardware reset held for 20 cycles, then each test in turn
  initial begin
    fails     = 0;
    n_checks  = 0;
    srst      = 1'h1;
    sw_reset  = 1'h0;
    reg_addr  = 5'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'h0;
    reg_read  = 1'h0;
    repeat (20) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    t_reset_values;
    t_abilities;
    t_latches;
    t_transmit;
    t_interrupts;
    t_soft_reset;
    stop_test;
  end

  // Watchdog, far beyond the roughly 150 cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    stop_test;
  end
endmodule // autoneg_next_page_regs_tb
`default_nettype wire
